// >>> include/jtcs_pkg.sv
// Constants and carriers for the JTAG control, status, readout and MEMORY_SELFTEST_RESULT paths
package jtcs_pkg;

  // Instruction register and its codes
  localparam int         IR_W      = 4;
  localparam logic [3:0] IR_CTRL   = 4'h9;
  localparam logic [3:0] IR_STAT   = 4'hA;
  localparam logic [3:0] IR_RDOUT  = 4'hB;
  localparam logic [3:0] IR_MEMORY_SELFTEST_RESULT   = 4'hC;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam logic [3:0] IR_CAPVAL = 4'h1;

  // Scan path lengths
  localparam int CTRL_W = 40;
  localparam int STAT_W = 54;
  localparam int RDO_W  = 33;
  localparam int MEMORY_SELFTEST_RESULT_W = 10;
  localparam int DR_W   = 54;

  // Unlock codes held in the low control field
  localparam logic [3:0] UNLOCK_DRV      = 4'h5;
  localparam logic [3:0] UNLOCK_PWR      = 4'h4;
  localparam logic [3:0] UNLOCK_PWR_MASK = 4'hE;
  localparam int         UNLOCK_MSB      = 3;

  // Memory self-test
  localparam int N_MEM     = 5;
  localparam int MEMORY_SELFTEST_RESULT_CLKS = 3200;
  localparam int N_CH      = 32;
  localparam int OCC_W     = 8;

  // Control path fields, bit 39 down to bit 0
  typedef struct packed {
    logic        parity;
    logic        pll_rst;
    logic        dll_rst;
    logic [31:0] ch_en;
    logic        glb_rst;
    logic [3:0]  unlock;
  } jtcs_ctrl_t;

  // Drivers locked, still powered down, parity bit keeps the word even
  localparam jtcs_ctrl_t CTRL_RST = 40'h80_0000_0008;

  // Status path fields, bit 53 down to bit 0
  typedef struct packed {
    logic [7:0]  grp0_level1_fill;
    logic [7:0]  grp1_level1_fill;
    logic [7:0]  grp2_level1_fill;
    logic [7:0]  grp3_level1_fill;
    logic        fifo_empty;
    logic        fifo_full;
    logic [7:0]  fifo_fill;
    logic [11:0] misc;
  } jtcs_stat_t;

  // Readout word, valid flag in bit 0
  typedef struct packed {
    logic [31:0] data;
    logic        valid;
  } jtcs_rdo_t;

  localparam jtcs_rdo_t RDO_RST = 33'h0_0000_0000;

  // Test access port controller states
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } jtcs_tap_t;

endpackage

// >>> design/jtcs_mbist.sv
// One memory self-test sequencer: done/bad pair for a single memory
`timescale 1ns/1ps
module jtcs_mbist
  import jtcs_pkg::*;
#(
  parameter int CLKS = MEMORY_SELFTEST_RESULT_CLKS
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  input  wire logic step_i,
  input  wire logic err_i,
  output logic      done_o,
  output logic      bad_o
);

  localparam int CW = $clog2(CLKS + 1);
  localparam logic [CW-1:0] LAST = CW'(CLKS - 1);

  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          done_ff, nxt_done;
  logic          bad_ff, nxt_bad;
  logic          err_ff, nxt_err;

  // Count test clocks; errors seen at any step spoil the verdict
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = done_ff;
    nxt_bad  = bad_ff;
    nxt_err  = err_ff;
    if (start_i) begin
      nxt_cnt  = '0;
      nxt_done = 1'b0;  // see [R21]
      nxt_bad  = 1'b1;  // see [R22]
      nxt_err  = 1'b0;
    end else if (step_i && !done_ff) begin
      nxt_err = err_ff | err_i;
      nxt_cnt = cnt_ff + CW'(1);
      if (cnt_ff == LAST) begin
        nxt_done = 1'b1;             // see [R21]
        nxt_bad  = err_ff | err_i;   // see [R22]
      end
    end
  end

  // State registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
      bad_ff  <= 1'b1;
      err_ff  <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
      bad_ff  <= nxt_bad;
      err_ff  <= nxt_err;
    end
  end

  assign done_o = done_ff;
  assign bad_o  = bad_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_DONE_AFTER_CLKS: // see [R21]
    assert property ($rose(done_ff) |-> $past(cnt_ff) == LAST)
    else $error("Test done before all clocks were given");
  AST_START_INIT: // see [R22]
    assert property (start_i |=> !done_ff && bad_ff)
    else $error("Test entry did not clear done and set bad");
  AST_BAD_HOLDS: // see [R22]
    assert property (!done_ff && !start_i |=> bad_ff || done_ff)
    else $error("Bad flag dropped before the test ended");

endmodule

// >>> design/jtcs_top.sv
// JTAG control, status, FIFO readout and memory self-test scan paths
//
// What this block does, and what the tester must do
// [R1] Readout bus drivers enabled only when unlock field equals 0101.
// [R2] Power-down left only when unlock field matches 010x.
// [R3] Test reset forces unlock field top bit to one.
// [R4] Global reset bit resets the device state like the reset pin.
// [R5] Thirty-two channel enables, changeable while running.
// [R6] DLL and PLL reset bits each start their loop's initialization.
// [R7] Control word carries an even parity bit.
// [R8] Global reset never reinitializes the PLL or the DLL.
// [R9] Tester resets PLL and DLL after power and clock are stable.
// [R10] Tester resets PLL first, waits for lock, then the DLL.
// [R11] Loop parameters are loaded before either reset bit is pulsed.
// [R12] After reloading setup data the reset sequence should be repeated.
// [R13] Occupancies sampled at status capture on the test clock.
// [R14] Status reports FIFO fill, full, empty and four group fills.
// [R15] Readout mode disables normal readout; data only via JTAG.
// [R16] Each update in readout mode pops one FIFO word if present.
// [R17] Readout word: valid flag in bit 0, data above it.
// [R18] MEMORY_SELFTEST_RESULT instruction puts memories in test; start on run-MEMORY_SELFTEST_RESULT entry.
// [R19] Tester gives at least 3200 test clocks in run-MEMORY_SELFTEST_RESULT.
// [R20] Result holds done/bad pairs: FIFO lowest, then groups 3..0.
// [R21] Done clears on run-MEMORY_SELFTEST_RESULT entry, sets after enough clocks.
// [R22] Bad sets on run-MEMORY_SELFTEST_RESULT entry, clears only on a clean finish.
// [R23] Shifted control data takes effect only at update.
`timescale 1ns/1ps
module jtcs_top
  import jtcs_pkg::*;
#(
  parameter int MBIST_CLKS = MEMORY_SELFTEST_RESULT_CLKS
) (
  input  wire logic       CLK_I,
  input  wire logic       NRST_I,
  input  wire logic       TCK_I,
  input  wire logic       TMS_I,
  input  wire logic       TDI_I,
  input  wire logic       TRST_N_I,
  output logic            TDO_O,
  output logic            TDO_OE_O,
  input  wire jtcs_stat_t STAT_I,
  input  wire logic       RDOUT_MODE_I,
  input  wire logic       FIFO_EMPTY_I,
  input  wire logic [31:0] FIFO_DATA_I,
  output logic            FIFO_POP_O,
  output logic            RDOUT_IF_EN_O,
  input  wire logic [4:0] MEM_ERR_I,
  output logic            MBIST_MODE_O,
  output logic            DRV_EN_O,
  output logic            PWR_ON_O,
  output logic            GLB_RST_O,
  output logic [31:0]     CH_EN_O,
  output logic            DLL_RST_O,
  output logic            PLL_RST_O,
  output logic            CTRL_PAR_OK_O
);

  // Pin synchronisers: bit 0 clock, 1 mode, 2 data in, 3 test reset
  logic [3:0] syn1_ff, syn2_ff;
  logic       tck_d_ff;
  logic       tck_rise, tck_fall, trst_act;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      syn1_ff  <= 4'h0;
      syn2_ff  <= 4'h0;
      tck_d_ff <= 1'b0;
    end else begin
      syn1_ff  <= {TRST_N_I, TDI_I, TMS_I, TCK_I};
      syn2_ff  <= syn1_ff;
      tck_d_ff <= syn2_ff[0];
    end
  end

  // Edges of the test clock as seen by the core clock
  assign tck_rise = syn2_ff[0] & ~tck_d_ff;
  assign tck_fall = ~syn2_ff[0] & tck_d_ff;
  assign trst_act = ~syn2_ff[3];

  // Controller, instruction, data shift, control word and readout holding
  jtcs_tap_t      tap_ff, nxt_tap;
  logic [IR_W-1:0] ir_sh_ff, nxt_ir_sh;
  logic [IR_W-1:0] ir_ff, nxt_ir;
  logic [DR_W-1:0] dr_sh_ff, nxt_dr_sh;
  jtcs_ctrl_t     ctrl_ff, nxt_ctrl;
  jtcs_rdo_t      rdo_ff, nxt_rdo;
  logic           pop_ff, nxt_pop;
  logic           tdo_ff, nxt_tdo;
  logic           tdo_oe_ff, nxt_tdo_oe;
  logic [MEMORY_SELFTEST_RESULT_W-1:0] memory_selftest_result_res;
  logic           memory_selftest_result_start, memory_selftest_result_step;
  logic           upd_ctrl, upd_rdo;
  int unsigned    dr_len;

  // Standard TAP walk, decided by the mode pin at each rising test clock
  function automatic jtcs_tap_t tap_next(jtcs_tap_t s, logic m);
    case (s)
      TLR:     tap_next = m ? TLR    : RTI;
      RTI:     tap_next = m ? SEL_DR : RTI;
      SEL_DR:  tap_next = m ? SEL_IR : CAP_DR;
      CAP_DR:  tap_next = m ? EX1_DR : SH_DR;
      SH_DR:   tap_next = m ? EX1_DR : SH_DR;
      EX1_DR:  tap_next = m ? UPD_DR : PA_DR;
      PA_DR:   tap_next = m ? EX2_DR : PA_DR;
      EX2_DR:  tap_next = m ? UPD_DR : SH_DR;
      UPD_DR:  tap_next = m ? SEL_DR : RTI;
      SEL_IR:  tap_next = m ? TLR    : CAP_IR;
      CAP_IR:  tap_next = m ? EX1_IR : SH_IR;
      SH_IR:   tap_next = m ? EX1_IR : SH_IR;
      EX1_IR:  tap_next = m ? UPD_IR : PA_IR;
      PA_IR:   tap_next = m ? EX2_IR : PA_IR;
      EX2_IR:  tap_next = m ? UPD_IR : SH_IR;
      UPD_IR:  tap_next = m ? SEL_DR : RTI;
      default: tap_next = TLR;
    endcase
  endfunction

  // Selected scan path length; unknown codes act as a one-bit bypass
  always_comb begin
    case (ir_ff)
      IR_CTRL:  dr_len = CTRL_W;
      IR_STAT:  dr_len = STAT_W;
      IR_RDOUT: dr_len = RDO_W;
      IR_MEMORY_SELFTEST_RESULT:  dr_len = MEMORY_SELFTEST_RESULT_W;
      default:  dr_len = 1;
    endcase
  end

  // Update strobes, one core cycle wide
  assign upd_ctrl = tck_rise && tap_ff == UPD_DR && ir_ff == IR_CTRL;
  assign upd_rdo  = tck_rise && tap_ff == UPD_DR && ir_ff == IR_RDOUT;

  // Self-test starts on any edge entering run-MEMORY_SELFTEST_RESULT, even from Update-IR
  assign memory_selftest_result_start = tck_rise && nxt_ir == IR_MEMORY_SELFTEST_RESULT && tap_ff != RTI &&
                      nxt_tap == RTI;                  // see [R18]
  assign memory_selftest_result_step  = tck_rise && ir_ff == IR_MEMORY_SELFTEST_RESULT && tap_ff == RTI;

  // Next values of the scan machinery
  always_comb begin
    nxt_tap    = tap_ff;
    nxt_ir_sh  = ir_sh_ff;
    nxt_ir     = ir_ff;
    nxt_dr_sh  = dr_sh_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_rdo    = rdo_ff;
    nxt_pop    = 1'b0;
    nxt_tdo    = tdo_ff;
    nxt_tdo_oe = tdo_oe_ff;
    if (trst_act) begin
      nxt_tap    = TLR;
      nxt_ir     = IR_BYPASS;
      nxt_tdo_oe = 1'b0;
      nxt_ctrl.unlock[UNLOCK_MSB] = 1'b1;              // see [R3]
    end else if (tck_rise) begin
      nxt_tap = tap_next(tap_ff, syn2_ff[1]);
      case (tap_ff)
        TLR:    nxt_ir    = IR_BYPASS;
        CAP_IR: nxt_ir_sh = IR_CAPVAL;
        SH_IR:  nxt_ir_sh = {syn2_ff[2], ir_sh_ff[IR_W-1:1]};
        UPD_IR: nxt_ir    = ir_sh_ff;
        CAP_DR: begin
          nxt_dr_sh = '0;
          case (ir_ff)
            IR_CTRL:  nxt_dr_sh[CTRL_W-1:0] = ctrl_ff;
            // Core values caught on the test clock; may be mid-change
            IR_STAT:  nxt_dr_sh[STAT_W-1:0] = STAT_I;  // see [R13] [R14]
            IR_RDOUT: nxt_dr_sh[RDO_W-1:0]  = rdo_ff;  // see [R17]
            IR_MEMORY_SELFTEST_RESULT:  nxt_dr_sh[MEMORY_SELFTEST_RESULT_W-1:0] = memory_selftest_result_res; // see [R20]
            default:  nxt_dr_sh = '0;
          endcase
        end
        SH_DR: begin
          nxt_dr_sh = {1'b0, dr_sh_ff[DR_W-1:1]};
          nxt_dr_sh[dr_len-1] = syn2_ff[2];
        end
        UPD_DR: begin
          // Control outputs move only here or at test reset, never while shifting
          if (ir_ff == IR_CTRL) begin
            nxt_ctrl = dr_sh_ff[CTRL_W-1:0];           // see [R23] [R5]
          end
          if (ir_ff == IR_RDOUT && RDOUT_MODE_I) begin
            nxt_pop = !FIFO_EMPTY_I;                   // see [R16]
            nxt_rdo.valid = !FIFO_EMPTY_I;             // see [R17]
            nxt_rdo.data  = FIFO_EMPTY_I ? 32'h0000_0000 : FIFO_DATA_I;
          end
        end
        default: nxt_tap = nxt_tap;
      endcase
    end else if (tck_fall) begin
      // Data out changes on the falling test clock, as the pin expects
      nxt_tdo_oe = tap_ff == SH_DR || tap_ff == SH_IR;
      if (tap_ff == SH_IR) begin
        nxt_tdo = ir_sh_ff[0];
      end else if (tap_ff == SH_DR) begin
        nxt_tdo = dr_sh_ff[0];
      end
    end
  end

  // Registers of the scan machinery; control word ignores the global reset
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      tap_ff    <= TLR;
      ir_sh_ff  <= IR_CAPVAL;
      ir_ff     <= IR_BYPASS;
      dr_sh_ff  <= '0;
      ctrl_ff   <= CTRL_RST;
      rdo_ff    <= RDO_RST;
      pop_ff    <= 1'b0;
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tap_ff    <= nxt_tap;
      ir_sh_ff  <= nxt_ir_sh;
      ir_ff     <= nxt_ir;
      dr_sh_ff  <= nxt_dr_sh;
      ctrl_ff   <= nxt_ctrl;
      rdo_ff    <= nxt_rdo;
      pop_ff    <= nxt_pop;
      tdo_ff    <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  // One sequencer per memory: 0 FIFO, 1..4 groups 3..0
  for (genvar i = 0; i < N_MEM; i++) begin : g_mem
    jtcs_mbist #(
      .CLKS (MBIST_CLKS)
    ) u_mbist (
      .clk_i   (CLK_I),
      .rst_n_i (NRST_I),
      .start_i (memory_selftest_result_start),
      .step_i  (memory_selftest_result_step),
      .err_i   (MEM_ERR_I[i]),
      .done_o  (memory_selftest_result_res[2*i]),                        // see [R20]
      .bad_o   (memory_selftest_result_res[2*i+1])
    );
  end

  // Decoded outputs, registered so the pins never glitch
  logic drv_en_ff, pwr_on_ff, par_ok_ff, glb_ff, ifen_ff, mbist_ff;
  logic nxt_drv_en, nxt_pwr_on, nxt_par_ok, nxt_glb, nxt_ifen;
  logic nxt_mbist;

  always_comb begin
    nxt_drv_en = ctrl_ff.unlock == UNLOCK_DRV;         // see [R1]
    nxt_pwr_on = (ctrl_ff.unlock & UNLOCK_PWR_MASK) == UNLOCK_PWR; // see [R2]
    nxt_par_ok = ~^ctrl_ff;                            // see [R7]
    nxt_glb    = ctrl_ff.glb_rst;                      // see [R4]
    nxt_ifen   = !RDOUT_MODE_I;                        // see [R15]
    nxt_mbist  = ir_ff == IR_MEMORY_SELFTEST_RESULT;                     // see [R18]
  end

  // Global reset output also stands while the pin reset is held
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      drv_en_ff <= 1'b0;
      pwr_on_ff <= 1'b0;
      par_ok_ff <= 1'b1;
      glb_ff    <= 1'b1;
      ifen_ff   <= 1'b1;
      mbist_ff  <= 1'b0;
    end else begin
      drv_en_ff <= nxt_drv_en;
      pwr_on_ff <= nxt_pwr_on;
      par_ok_ff <= nxt_par_ok;
      glb_ff    <= nxt_glb;
      ifen_ff   <= nxt_ifen;
      mbist_ff  <= nxt_mbist;
    end
  end

  assign TDO_O         = tdo_ff;
  assign TDO_OE_O      = tdo_oe_ff;
  assign FIFO_POP_O    = pop_ff;
  assign RDOUT_IF_EN_O = ifen_ff;
  assign MBIST_MODE_O  = mbist_ff;
  assign DRV_EN_O      = drv_en_ff;
  assign PWR_ON_O      = pwr_on_ff;
  assign GLB_RST_O     = glb_ff;
  assign CH_EN_O       = ctrl_ff.ch_en;                // see [R5]
  assign DLL_RST_O     = ctrl_ff.dll_rst;              // see [R6] [R8] [R12]
  assign PLL_RST_O     = ctrl_ff.pll_rst;              // see [R6] [R8]
  assign CTRL_PAR_OK_O = par_ok_ff;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  AST_DRV_UNLOCK: // see [R1]
    assert property (DRV_EN_O |-> $past(ctrl_ff.unlock) == UNLOCK_DRV)
    else $error("Drivers enabled without the unlock code");
  AST_PWR_UNLOCK: // see [R2]
    assert property (PWR_ON_O |-> $past(ctrl_ff.unlock[3:1]) == 3'h2)
    else $error("Power-down left without the unlock code");
  AST_TRST_LOCK: // see [R3]
    assert property (trst_act |=> ##1 !DRV_EN_O && !PWR_ON_O)
    else $error("Unlock still valid after test reset");
  AST_GLB_FOLLOW: // see [R4]
    assert property (upd_ctrl |=> ##1 GLB_RST_O == $past(dr_sh_ff[4], 2))
    else $error("Global reset output does not follow the control bit");
  AST_CTRL_AT_UPDATE: // see [R23]
    assert property (!upd_ctrl && !trst_act |=> $stable(ctrl_ff))
    else $error("Control word changed outside an update");
  AST_LOOPS_KEEP: // see [R8]
    assert property (!upd_ctrl |=> $stable({PLL_RST_O, DLL_RST_O}))
    else $error("Loop reset changed without a control update");
  AST_PARITY: // see [R7]
    assert property (CTRL_PAR_OK_O |-> !(^$past(ctrl_ff)))
    else $error("Parity reported good on an odd control word");
  AST_POP_CAUSE: // see [R16]
    assert property (FIFO_POP_O |-> $past(upd_rdo && RDOUT_MODE_I &&
                                          !FIFO_EMPTY_I))
    else $error("FIFO popped without an update in readout mode");
  AST_RDO_VALID: // see [R17]
    assert property (upd_rdo && RDOUT_MODE_I |=>
                     rdo_ff.valid == $past(!FIFO_EMPTY_I))
    else $error("Readout valid flag disagrees with FIFO state");
  AST_IF_OFF: // see [R15]
    assert property (RDOUT_IF_EN_O |-> !$past(RDOUT_MODE_I))
    else $error("Normal readout enabled in JTAG readout mode");
  AST_STAT_CAP: // see [R13]
    assert property (tck_rise && tap_ff == CAP_DR && ir_ff == IR_STAT
                     |=> dr_sh_ff == $past(STAT_I))
    else $error("Status capture did not sample the core state");
  AST_MEMORY_SELFTEST_RESULT_MODE: // see [R18]
    assert property (MBIST_MODE_O |-> $past(ir_ff) == IR_MEMORY_SELFTEST_RESULT)
    else $error("Self-test mode without the self-test instruction");

  COV_POP: cover property (FIFO_POP_O);
  COV_MEMORY_SELFTEST_RESULT_DONE: cover property ($rose(memory_selftest_result_res[0]));
  COV_DRV_ON: cover property ($rose(DRV_EN_O));
  COV_EMPTY_READ: cover property (upd_rdo && RDOUT_MODE_I && FIFO_EMPTY_I);

endmodule

// >>> sim/jtcs_tap_master.sv
// Behavioural test controller driving the JTAG pins of the block
`timescale 1ns/1ps
module jtcs_tap_master
  import jtcs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o
);
  // Pins idle at time zero; the test clock stands still between scans
  initial begin
    tck_o    = 1'h0;
    tms_o    = 1'h1;
    tdi_o    = 1'h0;
    trst_n_o = 1'h1;
  end

  // One 320 ns test clock period, four core cycles low and four high.
  // TDO is taken just after the rising pin edge, before the block can
  // see that edge, so the bit from the last falling edge is still there.
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tck_o <= 1'h0;
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (4) @(posedge clk_i);
    tck_o <= 1'h1;
    repeat (2) @(negedge clk_i);
    tdo = tdo_oe_i ? tdo_i : 1'hx;
    repeat (3) @(posedge clk_i);
  endtask

  // Five ticks with TMS high reach test-logic-reset, then idle
  task automatic tap_reset();
    logic b;
    repeat (5) tick(1'h1, 1'h0, b);
    tick(1'h0, 1'h0, b);
  endtask

  // Test reset pin held low for four core cycles, then back to idle
  task automatic test_reset();
    logic b;
    trst_n_o <= 1'h0;
    repeat (4) @(posedge clk_i);
    trst_n_o <= 1'h1;
    repeat (4) @(posedge clk_i);
    tick(1'h0, 1'h0, b);
  endtask

  // Full scan from idle back to idle, least significant bit first.
  // Returns one core cycle late so outputs launched by the update settle.
  task automatic scan(input logic ir, input int n,
                      input logic [DR_W-1:0] din,
                      output logic [DR_W-1:0] dout);
    logic b;
    dout = '0;
    tick(1'h1, 1'h0, b);
    if (ir) begin
      tick(1'h1, 1'h0, b);
    end
    tick(1'h0, 1'h0, b);
    tick(1'h0, 1'h0, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'h1, 1'h0, b);
    tick(1'h0, 1'h0, b);
    @(posedge clk_i);
  endtask
endmodule

// >>> sim/jtcs_top_test.sv
// Self-checking bench for the JTAG control, status, readout and MEMORY_SELFTEST_RESULT paths
`timescale 1ns/1ps
module jtcs_top_test;
  import jtcs_pkg::*;

  localparam int MB = 16;

  logic            clk, nrst, tck, tms, tdi, trst_n, tdo, tdo_oe;
  jtcs_stat_t      stat;
  logic            rdout_mode, fifo_empty, fifo_pop, rdout_if_en;
  logic            mbist_mode, drv_en, pwr_on, glb_rst, dll_rst, pll_rst;
  logic            par_ok, b;
  logic [31:0]     fifo_data, ch_en;
  logic [31:0]     fifo_mem [2];
  logic [32:0]     exp_rdo [4];
  logic [4:0]      mem_err;
  logic [1:0]      rd;
  logic [DR_W-1:0] q;
  logic [3:0]      codes [6];
  jtcs_ctrl_t      cur, w;
  int              error_cnt, checked, pops;

  always #20 clk = ~clk;

  // Two-word readout FIFO; the data lines turn over once it runs dry
  assign fifo_empty = (rd == 2'h2);
  assign fifo_data  = fifo_empty ? ~fifo_mem[1] : fifo_mem[rd[0]];
  always @(posedge clk) begin
    if (fifo_pop === 1'h1) begin
      rd   <= rd + 2'h1;
      pops <= pops + 1;
    end
  end

  jtcs_tap_master tap_u (
    .clk_i    (clk),
    .tdo_i    (tdo),
    .tdo_oe_i (tdo_oe),
    .tck_o    (tck),
    .tms_o    (tms),
    .tdi_o    (tdi),
    .trst_n_o (trst_n)
  );

  jtcs_top #(.MBIST_CLKS(MB)) dut_u (
    .CLK_I         (clk),
    .NRST_I        (nrst),
    .TCK_I         (tck),
    .TMS_I         (tms),
    .TDI_I         (tdi),
    .TRST_N_I      (trst_n),
    .TDO_O         (tdo),
    .TDO_OE_O      (tdo_oe),
    .STAT_I        (stat),
    .RDOUT_MODE_I  (rdout_mode),
    .FIFO_EMPTY_I  (fifo_empty),
    .FIFO_DATA_I   (fifo_data),
    .FIFO_POP_O    (fifo_pop),
    .RDOUT_IF_EN_O (rdout_if_en),
    .MEM_ERR_I     (mem_err),
    .MBIST_MODE_O  (mbist_mode),
    .DRV_EN_O      (drv_en),
    .PWR_ON_O      (pwr_on),
    .GLB_RST_O     (glb_rst),
    .CH_EN_O       (ch_en),
    .DLL_RST_O     (dll_rst),
    .PLL_RST_O     (pll_rst),
    .CTRL_PAR_OK_O (par_ok)
  );

  task automatic cmp(input logic [DR_W-1:0] got, input logic [DR_W-1:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Control word with its even parity bit filled in
  function automatic jtcs_ctrl_t mk(input logic [3:0] u, input logic g,
                                    input logic d, input logic p);
    jtcs_ctrl_t r;
    r = '{1'h0, p, d, {8{u}}, g, u};
    r.parity = ^r;
    return r;
  endfunction

  // Outputs expected from the control word now in force
  task automatic chk_outs();
    cmp(drv_en, cur.unlock == 4'h5, "drivers enable");
    cmp(pwr_on, cur.unlock[3:1] == 3'h2, "power up");
    cmp(glb_rst, cur.glb_rst, "global reset");
    cmp(ch_en, cur.ch_en, "channel enables");
    cmp(dll_rst, cur.dll_rst, "dll reset");
    cmp(pll_rst, cur.pll_rst, "pll reset");
    cmp(par_ok, ~^cur, "parity");
  endtask

  // Write a control word; the captured old word doubles as a readback
  task automatic wr_ctrl(input jtcs_ctrl_t nw);
    tap_u.scan(1'h1, IR_W, DR_W'(IR_CTRL), q);
    tap_u.scan(1'h0, CTRL_W, DR_W'(nw), q);
    cmp(q, DR_W'(cur), "control readback");
    cur = nw;
    chk_outs();
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run is near 0.36 ms; a hang is cut off well past that
  initial begin
    #3_000_000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    clk = 1'h0;
    nrst = 1'h0;
    stat = '0;
    rdout_mode = 1'h0;
    mem_err = 5'h00;
    rd = 2'h0;
    pops = 0;
    error_cnt = 0;
    checked = 0;
    cur = CTRL_RST;
    fifo_mem[0] = 32'h1234_5678;
    fifo_mem[1] = 32'hA5C3_0F96;
    codes = '{4'h5, 4'h4, 4'hD, 4'h7, 4'h1, 4'h5};
    repeat (10) @(posedge clk);
    cmp(glb_rst, 1'h1, "global reset in pin reset");
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
    tap_u.tap_reset();
    chk_outs();
    // Unlock codes, including near misses of both patterns
    for (int i = 0; i < 6; i++) begin
      wr_ctrl(mk(codes[i], 1'h0, 1'h0, 1'h0));
    end
    w = mk(4'h5, 1'h0, 1'h0, 1'h0);
    w.parity = ~w.parity;
    wr_ctrl(w);
    // Global reset pulse must leave both loop resets alone
    wr_ctrl(mk(4'h5, 1'h1, 1'h0, 1'h0));
    wr_ctrl(mk(4'h5, 1'h0, 1'h0, 1'h0));
    // Loop resets pulsed one at a time, PLL first; no setup path here
    wr_ctrl(mk(4'h5, 1'h0, 1'h0, 1'h1));
    wr_ctrl(mk(4'h5, 1'h0, 1'h0, 1'h0));
    wr_ctrl(mk(4'h5, 1'h0, 1'h1, 1'h0));
    wr_ctrl(mk(4'h5, 1'h0, 1'h0, 1'h0));
    // Test reset locks both unlock codes, other bits kept
    tap_u.test_reset();
    cur.unlock[3] = 1'h1;
    chk_outs();
    wr_ctrl(mk(4'h4, 1'h0, 1'h0, 1'h0));
    // Status snapshot taken at capture
    stat <= jtcs_stat_t'(54'h2A_5C3F_0E1D_B796);
    tap_u.scan(1'h1, IR_W, DR_W'(IR_STAT), q);
    tap_u.scan(1'h0, STAT_W, '0, q);
    cmp(q, DR_W'(54'h2A_5C3F_0E1D_B796), "status");
    // Readout words popped one per update, then an empty word
    exp_rdo = '{33'h0, {fifo_mem[0], 1'h1}, {fifo_mem[1], 1'h1}, 33'h0};
    rdout_mode <= 1'h1;
    repeat (2) @(posedge clk);
    cmp(rdout_if_en, 1'h0, "normal readout off");
    tap_u.scan(1'h1, IR_W, DR_W'(IR_RDOUT), q);
    for (int i = 0; i < 4; i++) begin
      tap_u.scan(1'h0, RDO_W, '0, q);
      cmp(q, DR_W'(exp_rdo[i]), "readout word");
    end
    cmp(DR_W'(pops), DR_W'(2), "pop count");
    rdout_mode <= 1'h0;
    rd <= 2'h0;
    tap_u.scan(1'h0, RDO_W, '0, q);
    cmp(q, DR_W'(0), "word kept outside mode");
    cmp(DR_W'(pops), DR_W'(2), "no pop outside mode");
    cmp(rdout_if_en, 1'h1, "normal readout on");
    // Self-test with an error in group 2, then a clean rerun
    mem_err <= 5'h04;
    tap_u.scan(1'h1, IR_W, DR_W'(IR_MEMORY_SELFTEST_RESULT), q);
    cmp(mbist_mode, 1'h1, "self-test mode");
    tap_u.scan(1'h0, MEMORY_SELFTEST_RESULT_W, '0, q);
    cmp(q, DR_W'(10'h2AA), "self-test running");
    repeat (MB + 4) tap_u.tick(1'h0, 1'h0, b);
    tap_u.scan(1'h0, MEMORY_SELFTEST_RESULT_W, '0, q);
    cmp(q, DR_W'(10'h175), "self-test failed");
    mem_err <= 5'h00;
    repeat (MB + 4) tap_u.tick(1'h0, 1'h0, b);
    tap_u.scan(1'h0, MEMORY_SELFTEST_RESULT_W, '0, q);
    cmp(q, DR_W'(10'h155), "self-test clean");
    print_verdict();
  end
endmodule
